// File: pwt_pkg.sv
// constants, types and register map of the pwm / wait one-shot timer
// assumes an axi4-lite master on the same 20 MHz ref_clk
package pwt_pkg;

  localparam int CNT_W = 16;
  localparam int AXI_AW = 6;

  // byte offsets
  localparam logic [AXI_AW-1:0] OFS_MODE   = 6'h00;
  localparam logic [AXI_AW-1:0] OFS_CTRL1  = 6'h04;
  localparam logic [AXI_AW-1:0] OFS_CTRL2  = 6'h08;
  localparam logic [AXI_AW-1:0] OFS_COUNT  = 6'h0C;
  localparam logic [AXI_AW-1:0] OFS_CMP_A  = 6'h10;
  localparam logic [AXI_AW-1:0] OFS_CMP_B  = 6'h14;
  localparam logic [AXI_AW-1:0] OFS_CMP_C  = 6'h18;
  localparam logic [AXI_AW-1:0] OFS_CMP_D  = 6'h1C;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 6'h20;

  // timer_mode_reg fields
  localparam int MODE_START_BIT   = 0;
  localparam int MODE_ONESHOT_BIT = 1;
  localparam int MODE_BFC_BIT     = 2;
  localparam int MODE_BFD_BIT     = 3;
  // timer_control_reg_1 fields
  localparam int C1_SRC_LSB   = 0;
  localparam int C1_CLR_BIT   = 3;
  localparam int C1_INITB_BIT = 4;
  localparam int C1_INITC_BIT = 5;
  localparam int C1_INITD_BIT = 6;
  // timer_control_reg_2 fields
  localparam int C2_CSS_BIT    = 0;
  localparam int C2_TEDGE_LSB  = 1;
  // status fields, write one to clear
  localparam int ST_MATCH_A_BIT = 0;
  localparam int ST_OVF_BIT     = 4;

  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0] CMP_RST  = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [1:0]       RESP_OK  = 2'h0;
  localparam logic [1:0]       RESP_ERR = 2'h2;

  typedef enum logic [2:0] {
    SRC_F1   = 3'h0,
    SRC_F2   = 3'h1,
    SRC_F4   = 3'h2,
    SRC_F8   = 3'h3,
    SRC_F32  = 3'h4,
    SRC_OSC  = 3'h5,
    SRC_EXT  = 3'h6
  } pwt_src_e;

  typedef enum logic [1:0] {
    TRG_NONE = 2'h0,
    TRG_RISE = 2'h1,
    TRG_FALL = 2'h2,
    TRG_BOTH = 2'h3
  } pwt_trg_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ARMED = 2'h1,
    ST_RUN   = 2'h3
  } pwt_state_e;

  typedef struct packed {
    logic     oneshot;
    logic     bfc;
    logic     bfd;
    logic     css;
    logic     clr;
    pwt_trg_e tedge;
    pwt_src_e src;
    logic     init_b;
    logic     init_c;
    logic     init_d;
  } pwt_cfg_s;

  localparam pwt_cfg_s CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                   TRG_NONE, SRC_F1, 1'b0, 1'b0, 1'b0};

endpackage

// File: pwt_pin_sync.sv
// two-flop synchroniser with edge detect for one outside pin
// assumes pin is asynchronous to ref_clk
`timescale 1ns/1ns
module pwt_pin_sync
  import pwt_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;

endmodule

// File: pwt_prescaler.sv
// free divider giving one-cycle enables at 1/1, 1/2, 1/4, 1/8, 1/32
// assumes single ref_clk domain
`timescale 1ns/1ns
module pwt_prescaler
  import pwt_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  output logic [4:0]      tick
);

  logic [4:0] div_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 5'h00;
    end else begin
      div_reg <= div_reg + 5'h01;
    end
  end

  assign tick[0] = 1'b1;
  assign tick[1] = div_reg[0];
  assign tick[2] = &div_reg[1:0];
  assign tick[3] = &div_reg[2:0];
  assign tick[4] = &div_reg[4:0];

endmodule

// File: pwt_top.sv
// pwm / wait one-shot timer with axi4-lite register slave
// assumes pins asynchronous to ref_clk, master follows axi4-lite handshakes
`timescale 1ns/1ns
module pwt_top
  import pwt_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              external_trigger_pin,
  input  wire logic              external_clock_pin,
  input  wire logic              fast_onchip_osc_clock,
  output logic                   output_pin_b,
  output logic                   output_pin_c,
  output logic                   output_pin_d,
  output logic                   irq_req
);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---------------- pins and count source
  logic [2:0] pin_raw;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic [4:0] div_tick;

  assign pin_raw = {fast_onchip_osc_clock, external_clock_pin,
                    external_trigger_pin};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      pwt_pin_sync u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .pin_in  (pin_raw[g]),
        .rise    (pin_rise[g]),
        .fall    (pin_fall[g])
      );
    end
  endgenerate

  pwt_prescaler u_pre (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .tick    (div_tick)
  );

  // ---------------- registers
  pwt_cfg_s         cfg_reg;
  pwt_state_e       state_reg;
  pwt_state_e       state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] cmp_a_reg;
  logic [CNT_W-1:0] cmp_b_reg;
  logic [CNT_W-1:0] cmp_c_reg;
  logic [CNT_W-1:0] cmp_d_reg;
  logic [4:0]       status_reg;
  logic [AXI_AW-1:0] aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;

  logic src_tick;
  assign src_tick = (cfg_reg.src == SRC_F1)  ? div_tick[0] :
                    (cfg_reg.src == SRC_F2)  ? div_tick[1] :
                    (cfg_reg.src == SRC_F4)  ? div_tick[2] :
                    (cfg_reg.src == SRC_F8)  ? div_tick[3] :
                    (cfg_reg.src == SRC_F32) ? div_tick[4] :
                    (cfg_reg.src == SRC_OSC) ? pin_rise[2] :
                    (cfg_reg.src == SRC_EXT) ? pin_rise[1] : 1'b0;

  logic trig_hit;
  assign trig_hit = (cfg_reg.tedge == TRG_RISE) ? pin_rise[0] :
                    (cfg_reg.tedge == TRG_FALL) ? pin_fall[0] :
                    (cfg_reg.tedge == TRG_BOTH) ? (pin_rise[0] | pin_fall[0])
                                                : 1'b0;

  // ---------------- axi write side
  logic               wr_go;
  logic [3:0]         wr_idx;
  logic               wr_mapped;
  logic [31:0]        wr_merged;
  logic               wr_mode;
  logic               wr_ctrl1;
  logic               wr_ctrl2;
  logic               wr_cnt;
  logic               wr_a;
  logic               wr_b;
  logic               wr_c;
  logic               wr_d;
  logic               wr_st;
  logic [31:0]        wr_old;

  assign wr_go     = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_idx    = aw_addr_reg[5:2];
  assign wr_mapped = aw_addr_reg <= OFS_STATUS;
  assign wr_mode   = wr_go & (aw_addr_reg[5:2] == OFS_MODE[5:2]);
  assign wr_ctrl1  = wr_go & (wr_idx == OFS_CTRL1[5:2]);
  assign wr_ctrl2  = wr_go & (wr_idx == OFS_CTRL2[5:2]);
  assign wr_cnt    = wr_go & (wr_idx == OFS_COUNT[5:2]);
  assign wr_a      = wr_go & (wr_idx == OFS_CMP_A[5:2]);
  assign wr_b      = wr_go & (wr_idx == OFS_CMP_B[5:2]);
  assign wr_c      = wr_go & (wr_idx == OFS_CMP_C[5:2]);
  assign wr_d      = wr_go & (wr_idx == OFS_CMP_D[5:2]);
  assign wr_st     = wr_go & (wr_idx == OFS_STATUS[5:2]);
  assign wr_merged = merge(wr_old, w_data_reg, w_strb_reg);

  // ---------------- read mux
  logic [31:0] rd_mode;
  logic [31:0] rd_ctrl1;
  logic [31:0] rd_ctrl2;
  logic [31:0] rd_word;
  logic [3:0]  rd_idx;

  assign rd_mode  = {28'h0000000, cfg_reg.bfd, cfg_reg.bfc,
                     cfg_reg.oneshot, state_reg != ST_IDLE};
  assign rd_ctrl1 = {25'h0000000, cfg_reg.init_d, cfg_reg.init_c,
                     cfg_reg.init_b, cfg_reg.clr, cfg_reg.src};
  assign rd_ctrl2 = {29'h00000000, cfg_reg.tedge, cfg_reg.css};
  assign rd_idx   = s_axi_araddr[5:2];
  assign rd_word  = (rd_idx == OFS_MODE[5:2])   ? rd_mode  :
                    (rd_idx == OFS_CTRL1[5:2])  ? rd_ctrl1 :
                    (rd_idx == OFS_CTRL2[5:2])  ? rd_ctrl2 :
                    (rd_idx == OFS_COUNT[5:2])  ? {16'h0000, cnt_reg}   :
                    (rd_idx == OFS_CMP_A[5:2])  ? {16'h0000, cmp_a_reg} :
                    (rd_idx == OFS_CMP_B[5:2])  ? {16'h0000, cmp_b_reg} :
                    (rd_idx == OFS_CMP_C[5:2])  ? {16'h0000, cmp_c_reg} :
                    (rd_idx == OFS_CMP_D[5:2])  ? {16'h0000, cmp_d_reg} :
                    (rd_idx == OFS_STATUS[5:2]) ? {27'h0000000, status_reg}
                                                : 32'h00000000;
  assign wr_old   = (wr_idx == OFS_MODE[5:2])  ? rd_mode  :
                    (wr_idx == OFS_CTRL1[5:2]) ? rd_ctrl1 :
                    (wr_idx == OFS_CTRL2[5:2]) ? rd_ctrl2 :
                    (wr_idx == OFS_COUNT[5:2]) ? {16'h0000, cnt_reg}   :
                    (wr_idx == OFS_CMP_A[5:2]) ? {16'h0000, cmp_a_reg} :
                    (wr_idx == OFS_CMP_B[5:2]) ? {16'h0000, cmp_b_reg} :
                    (wr_idx == OFS_CMP_C[5:2]) ? {16'h0000, cmp_c_reg} :
                    (wr_idx == OFS_CMP_D[5:2]) ? {16'h0000, cmp_d_reg} :
                                                 32'h00000000;

  // ---------------- timer core decode
  logic start_wr1;
  logic start_wr0;
  logic trig_mode;
  logic step;
  logic m_a;
  logic m_b;
  logic m_c;
  logic m_d;
  logic period_end;
  logic os_stop;
  logic ovf;
  logic trig_start;

  assign start_wr1  = wr_mode & wr_merged[MODE_START_BIT];
  assign start_wr0  = wr_mode & ~wr_merged[MODE_START_BIT];
  assign trig_mode  = (cfg_reg.tedge != TRG_NONE) & cfg_reg.css;
  assign step       = (state_reg == ST_RUN) & src_tick & ~wr_mode;
  assign m_a        = cnt_reg == cmp_a_reg;
  assign m_b        = cnt_reg == cmp_b_reg;
  assign m_c        = cnt_reg == cmp_c_reg;
  assign m_d        = cnt_reg == cmp_d_reg;
  assign period_end = step & m_a;
  assign os_stop    = period_end & cfg_reg.oneshot & cfg_reg.css;
  assign ovf        = step & ~m_a & (cnt_reg == CNT_MAX);
  assign trig_start = (state_reg == ST_ARMED) & trig_hit & ~wr_mode;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (start_wr1) begin
                  state_next = trig_mode ? ST_ARMED : ST_RUN;
                end
      ST_ARMED: if (start_wr0) begin
                  state_next = ST_IDLE;
                end else if (trig_start) begin
                  state_next = ST_RUN;
                end
      ST_RUN:   if (start_wr0) begin
                  state_next = ST_IDLE;
                end else if (os_stop) begin
                  state_next = trig_mode ? ST_ARMED : ST_IDLE;
                end
      default:  state_next = ST_IDLE;
    endcase
  end

  always_comb begin
    cnt_next = cnt_reg;
    if (wr_cnt) begin
      cnt_next = wr_merged[CNT_W-1:0];
    end else if (trig_start) begin
      cnt_next = CNT_RST;
    end else if (period_end) begin
      cnt_next = (os_stop & ~cfg_reg.clr) ? cnt_reg : CNT_RST;
    end else if (step) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  // pwm output change: active on own match, home on period match, no change when own compare equals period
  function automatic logic pwm_next(input logic cur,
                                    input logic init,
                                    input logic m_own,
                                    input logic eq_a);
    logic res;
    res = cur;
    if (!eq_a && m_own) begin
      res = ~init;
    end else if (!eq_a && m_a) begin
      res = init;
    end
    return res;
  endfunction

  logic out_b_next;
  logic out_c_next;
  logic out_d_next;
  logic idle_out;

  assign idle_out = (state_reg != ST_RUN) | start_wr0;

  always_comb begin
    out_b_next = output_pin_b;
    out_c_next = output_pin_c;
    out_d_next = output_pin_d;
    if (idle_out) begin
      out_b_next = cfg_reg.init_b;
      out_c_next = cfg_reg.init_c;
      out_d_next = cfg_reg.init_d;
    end else if (step && cfg_reg.oneshot) begin
      if (m_a || m_b) begin
        out_b_next = cfg_reg.init_b;
      end else if (m_c) begin
        out_b_next = ~cfg_reg.init_b;
      end
    end else if (step) begin
      out_b_next = pwm_next(output_pin_b, cfg_reg.init_b, m_b,
                            cmp_b_reg == cmp_a_reg);
      out_c_next = cfg_reg.bfc ? cfg_reg.init_c :
                   pwm_next(output_pin_c, cfg_reg.init_c, m_c,
                            cmp_c_reg == cmp_a_reg);
      out_d_next = cfg_reg.bfd ? cfg_reg.init_d :
                   pwm_next(output_pin_d, cfg_reg.init_d, m_d,
                            cmp_d_reg == cmp_a_reg);
    end
  end

  logic [4:0] evt;
  assign evt = {ovf, step & m_d, step & m_c, step & m_b, step & m_a};

  // ---------------- sequential
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= CNT_RST;
      output_pin_b <= 1'b0;
      output_pin_c <= 1'b0;
      output_pin_d <= 1'b0;
      irq_req      <= 1'b0;
      status_reg   <= 5'h00;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      output_pin_b <= out_b_next;
      output_pin_c <= out_c_next;
      output_pin_d <= out_d_next;
      irq_req      <= |evt;
      // set wins over write-one clear
      status_reg   <= (status_reg & ~(wr_st ? wr_merged[4:0] : 5'h00)) | evt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= CFG_RST;
    end else if (wr_mode) begin
      cfg_reg.oneshot <= wr_merged[MODE_ONESHOT_BIT];
      cfg_reg.bfc     <= wr_merged[MODE_BFC_BIT];
      cfg_reg.bfd     <= wr_merged[MODE_BFD_BIT];
    end else if (wr_ctrl1) begin
      cfg_reg.src     <= pwt_src_e'(wr_merged[C1_SRC_LSB +: 3]);
      cfg_reg.clr     <= wr_merged[C1_CLR_BIT];
      cfg_reg.init_b  <= wr_merged[C1_INITB_BIT];
      cfg_reg.init_c  <= wr_merged[C1_INITC_BIT];
      cfg_reg.init_d  <= wr_merged[C1_INITD_BIT];
    end else if (wr_ctrl2) begin
      cfg_reg.css     <= wr_merged[C2_CSS_BIT];
      cfg_reg.tedge   <= pwt_trg_e'(wr_merged[C2_TEDGE_LSB +: 2]);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_a_reg <= CMP_RST;
      cmp_b_reg <= CMP_RST;
      cmp_c_reg <= CMP_RST;
      cmp_d_reg <= CMP_RST;
    end else begin
      if (wr_a) begin
        cmp_a_reg <= wr_merged[CNT_W-1:0];
      end else if (period_end && cfg_reg.bfc && !cfg_reg.oneshot) begin
        cmp_a_reg <= cmp_c_reg;
      end
      if (wr_b) begin
        cmp_b_reg <= wr_merged[CNT_W-1:0];
      end else if (period_end && cfg_reg.bfd) begin
        cmp_b_reg <= cmp_d_reg;
      end
      if (wr_c) begin
        cmp_c_reg <= wr_merged[CNT_W-1:0];
      end
      if (wr_d) begin
        cmp_d_reg <= wr_merged[CNT_W-1:0];
      end
    end
  end

  // axi handshakes; ready low means item held
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      aw_addr_reg   <= OFS_MODE;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_reg   <= s_axi_awaddr;
      end else if (wr_go) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
      end else if (wr_go) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= (s_axi_araddr <= OFS_STATUS) ? RESP_OK : RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_PERIOD_WRAP: assert property (
    period_end && !cfg_reg.oneshot && !wr_cnt |=> cnt_reg == CNT_RST)
    else $error("pwm count did not wrap at period");
  AST_B_ACTIVE: assert property (
    step && !cfg_reg.oneshot && m_b && cmp_b_reg != cmp_a_reg
    |=> output_pin_b == ~cfg_reg.init_b)
    else $error("output b missed its change point");
  AST_BUF_PERIOD: assert property (
    period_end && cfg_reg.bfc && !cfg_reg.oneshot && !wr_a
    |=> cmp_a_reg == $past(cmp_c_reg))
    else $error("buffered period not loaded");
  AST_EQ_HOLD: assert property (
    step && !cfg_reg.oneshot && m_a && cmp_b_reg == cmp_a_reg
    |=> $stable(output_pin_b))
    else $error("output b moved on period-equal match");
  AST_OS_ACTIVE: assert property (
    step && cfg_reg.oneshot && m_c && !m_b && !m_a
    |=> output_pin_b != cfg_reg.init_b)
    else $error("one-shot output not active after wait");
  AST_OS_STOP: assert property (
    os_stop |=> state_reg != ST_RUN && output_pin_b == cfg_reg.init_b)
    else $error("one-shot did not halt with output");
  AST_SW_STOP: assert property (
    start_wr0 && !wr_cnt
    |=> state_reg == ST_IDLE && $stable(cnt_reg)
        && output_pin_b == cfg_reg.init_b)
    else $error("software stop misbehaved");
  AST_TRIG_WAIT: assert property (
    state_reg == ST_ARMED && !trig_hit && !wr_mode |=> state_reg == ST_ARMED)
    else $error("count began without trigger");
  AST_IRQ: assert property (
    step && (m_a || m_b) |=> irq_req && status_reg[ST_MATCH_A_BIT +: 2] != 0)
    else $error("match gave no interrupt request");
  AST_HOLD_COUNT: assert property (
    state_reg != ST_RUN && !wr_cnt && !trig_start |=> $stable(cnt_reg))
    else $error("counter moved while not running");

  COV_PWM_PERIOD: cover property (period_end && !cfg_reg.oneshot);
  COV_OS_STOP:    cover property (os_stop);
  COV_TRIG:       cover property (trig_start);
  COV_OVF:        cover property (ovf);

endmodule

// File: pwt_far.sv
// far side of the timer: trigger source and gated clock pin
// assumes each change of fire or clk_go asks for one burst
`timescale 1ns/1ns
module pwt_far (
  input  wire logic ref_clk,
  input  wire logic fire,
  input  wire logic clk_go,
  output logic      trig_pin,
  output logic      clk_pin
);
  initial trig_pin = 1'b0;
  initial clk_pin = 1'b0;
  always @(fire) begin
    repeat (2) @(posedge ref_clk);
    trig_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    trig_pin <= 1'b0;
  end
  always @(clk_go) begin
    repeat (5) begin
      repeat (2) @(posedge ref_clk);
      clk_pin <= 1'b1;
      repeat (2) @(posedge ref_clk);
      clk_pin <= 1'b0;
    end
  end
endmodule

// File: tb_top.sv
// self-checking bench of the pwm / wait one-shot timer
// assumes pwt_pkg, pwt_top and pwt_far are compiled first
`timescale 1ns/1ns
module tb_top;
  import pwt_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [5:0]  s_axi_awaddr = 6'h00;
  logic [5:0]  s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, fire = 1'b0;
  logic        clk_go = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, output_pin_b, output_pin_c, output_pin_d;
  logic        irq_req, external_trigger_pin, external_clock_pin;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  int          fail_count = 0, n_compared = 0, n_irq = 0, hb, hc, hd;
  // a b c d mode : b c d high cycles in 100
  int          rows [4][8] = '{'{9, 3, 9, 5, 1, 60, 0, 40},
                               '{9, 3, 19, 9, 5, 80, 0, 50},
                               '{9, 3, 6, 1, 9, 80, 30, 0},
                               '{9, 9, 3, 9, 1, 0, 60, 0}};

  pwt_top pwt_top_i (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_trigger_pin,
    .external_clock_pin, .fast_onchip_osc_clock(external_clock_pin),
    .output_pin_b, .output_pin_c, .output_pin_d, .irq_req);
  // fast oscillator input shares the far model's clock pin
  pwt_far pwt_far_i (.ref_clk, .fire, .clk_go,
    .trig_pin(external_trigger_pin), .clk_pin(external_clock_pin));

  always #25 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (irq_req === 1'b1) n_irq++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ready seen at negedge is what the next rising edge samples
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic ha, hw, h;
    logic [1:0] br;
    h = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!h) begin
      @(negedge ref_clk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      h = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge ref_clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(br, (a <= OFS_STATUS) ? RESP_OK : RESP_ERR);
  endtask

  task automatic rdx(input logic [5:0] a);
    logic ha, h;
    h = 1'b0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!h) begin
      @(negedge ref_clk);
      ha = s_axi_arvalid & s_axi_arready;
      h = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge ref_clk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(rr, (a <= OFS_STATUS) ? RESP_OK : RESP_ERR);
  endtask

  task automatic hist(input int n);
    hb = 0;
    hc = 0;
    hd = 0;
    repeat (n) begin
      @(negedge ref_clk);
      hb += int'(output_pin_b === 1'b1);
      hc += int'(output_pin_c === 1'b1);
      hd += int'(output_pin_d === 1'b1);
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #1000000;
    fail_count++;
    test_done;
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk({output_pin_b, output_pin_c, output_pin_d, irq_req}, 32'h0);
    rdx(OFS_COUNT);
    chk(rd, 32'h0);
    rdx(OFS_CMP_A);
    chk(rd, 32'hFFFF);
    rdx(6'h24);
    chk(rr, RESP_ERR);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_MODE, 32'h0);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_CMP_A, rows[i][0]);
      wr(OFS_CMP_B, rows[i][1]);
      wr(OFS_CMP_C, rows[i][2]);
      wr(OFS_CMP_D, rows[i][3]);
      wr(OFS_MODE, rows[i][4]);
      repeat (40) @(posedge ref_clk);
      hist(100);
      chk(hb, rows[i][5]);
      chk(hc, rows[i][6]);
      chk(hd, rows[i][7]);
    end
    wr(OFS_MODE, 32'h0);
    wr(OFS_COUNT, 32'h7);
    repeat (20) @(posedge ref_clk);
    rdx(OFS_COUNT);
    chk(rd, 32'h7);
    chk(output_pin_b, 1'b0);
    // triggered one-shot, b differs from c
    wr(OFS_CTRL2, 32'h3);
    wr(OFS_CMP_A, 32'h14);
    wr(OFS_CMP_B, 32'hC);
    wr(OFS_CMP_C, 32'h4);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_MODE, 32'h3);
    repeat (30) @(posedge ref_clk);
    rdx(OFS_COUNT);
    chk(rd, 32'h0);
    @(posedge ref_clk);
    fire <= 1'b1;
    hist(80);
    chk(hb, 8);
    chk(output_pin_b, 1'b0);
    rdx(OFS_COUNT);
    chk(rd, 32'h14);
    wr(OFS_CTRL1, 32'h8);
    fire <= ~fire;
    repeat (60) @(posedge ref_clk);
    rdx(OFS_COUNT);
    chk(rd, 32'h0);
    wr(OFS_CTRL2, 32'h0);
    for (int s = 5; s < 7; s++) begin
      wr(OFS_MODE, 32'h0);
      wr(OFS_CTRL1, 32'h10 + s);
      wr(OFS_COUNT, 32'h0);
      wr(OFS_MODE, 32'h1);
      clk_go <= ~clk_go;
      repeat (40) @(posedge ref_clk);
      rdx(OFS_COUNT);
      chk(rd, 32'h5);
    end
    wr(OFS_MODE, 32'h0);
    @(negedge ref_clk);
    chk(output_pin_b, 1'b1);
    chk(n_irq > 0, 1'b1);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk({output_pin_b, output_pin_c, output_pin_d, irq_req}, 32'h0);
    rdx(OFS_CTRL1);
    chk(rd, 32'h0);
    test_done;
  end
endmodule
